// ==== include/smer_pkg.sv ====
// shared constants and carriers of the system management event router
package smer_pkg;

  localparam int EVT_W = 20;

  // event bit positions
  localparam int EV_SMB_HOST    = 0;
  localparam int EV_SMB_SLAVE   = 1;
  localparam int EV_SMB_SNOOP   = 2;
  localparam int EV_SMB_ALERT   = 3;
  localparam int EV_IRQ_ACT     = 4;
  localparam int EV_INTR        = 5;
  localparam int EV_BUS_MASTER  = 6;
  localparam int EV_HW_TRAP     = 7;
  localparam int EV_LPT_TRAP    = 8;
  localparam int EV_INACTIVITY  = 9;
  localparam int EV_FW_WE_RISE  = 10;
  localparam int EV_USB_XACT0   = 11;
  localparam int EV_USB_RESUME  = 15;
  localparam int EV_EXT_SMI     = 16;
  localparam int EV_BUTTON      = 17;
  localparam int EV_RING        = 18;
  localparam int EV_THERMAL     = 19;

  // which paths exist for each event
  localparam logic [19:0] CAP_ACPI   = 20'hFFB8F;
  localparam logic [19:0] CAP_SMI    = 20'hF8681;
  localparam logic [19:0] CAP_RELOAD = 20'h001F0;
  localparam logic [19:0] CAP_C2C3   = 20'h7826E;
  localparam logic [19:0] CAP_POS    = 20'h7822E;
  localparam logic [19:0] CAP_SLEEP  = 20'h78006;

  // summary groups
  localparam logic [19:0] GRP_SMB   = 20'h0000F;
  localparam logic [19:0] GRP_ACT   = 20'h00070;
  localparam logic [19:0] GRP_TRAP  = 20'h00180;
  localparam logic [19:0] GRP_TIMER = 20'h00200;
  localparam logic [19:0] GRP_MISC  = 20'h00400;
  localparam logic [19:0] GRP_USB   = 20'h0F800;
  localparam logic [19:0] GRP_PINS  = 20'hF0000;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_ACPI_EN    = 8'h04;
  localparam logic [7:0] OFS_SMI_EN     = 8'h08;
  localparam logic [7:0] OFS_RELOAD_EN  = 8'h0C;
  localparam logic [7:0] OFS_RES_C2C3   = 8'h10;
  localparam logic [7:0] OFS_RES_POS    = 8'h14;
  localparam logic [7:0] OFS_RES_SLEEP  = 8'h18;
  localparam logic [7:0] OFS_CTRL       = 8'h1C;
  localparam logic [7:0] OFS_SUMMARY    = 8'h20;

  // values after reset
  localparam logic [19:0] RST_EN     = 20'h00000;
  localparam logic        RST_ROUTE  = 1'h0;

  // one-hot power state from the power state machine
  localparam int PS_FON  = 0;
  localparam int PS_C2   = 1;
  localparam int PS_C3   = 2;
  localparam int PS_POS  = 3;
  localparam int PS_STD  = 4;
  localparam int PS_STR  = 5;
  localparam int PS_SOFF = 6;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } smer_avl_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } smer_avl_rsp_t;

endpackage

// ==== core/smer_router.sv ====
// system management event router: status, enables, routing and resume
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

module smer_router (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  input  wire smer_pkg::smer_avl_req_t avl_req_in,
  output smer_pkg::smer_avl_rsp_t    avl_rsp_out,
  input  wire logic [19:0]           events_in,
  input  wire logic [6:0]            power_state_machine_in,
  output logic                       sci_out,
  output logic                       smi_out,
  output logic                       inactivity_reload_out,
  output logic                       resume_out
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [19:0] prev;
    logic [19:0] status;
    logic [19:0] acpi_en;
    logic [19:0] smi_en;
    logic [19:0] reload_en;
    logic [19:0] res_c2c3;
    logic [19:0] res_pos;
    logic [19:0] res_sleep;
    logic        acpi_route_select;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sci;
    logic        smi;
    logic        reload;
    logic        resume;
  } smer_state_t;

  localparam smer_state_t ST_RESET = '{
    sync1: 20'h00000, sync2: 20'h00000, prev: 20'h00000,
    status: 20'h00000, acpi_en: smer_pkg::RST_EN,
    smi_en: smer_pkg::RST_EN, reload_en: smer_pkg::RST_EN,
    res_c2c3: smer_pkg::RST_EN, res_pos: smer_pkg::RST_EN,
    res_sleep: smer_pkg::RST_EN,
    acpi_route_select: smer_pkg::RST_ROUTE,
    readdata: 32'h00000000, waitrequest: 1'h1,
    sci: 1'h0, smi: 1'h0, reload: 1'h0, resume: 1'h0};

  smer_state_t r;
  smer_state_t n;

  logic [19:0] rise;
  logic [31:0] wmask;
  logic [19:0] wdat;
  logic [19:0] wm;
  logic [6:0]  summary;
  logic        acpi_req;
  logic        smi_only_req;
  logic [19:0] res_sel;
  logic        bus_req;
  logic        do_wr;
  logic [31:0] rd_val;
  logic [7:0]  adr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    // second stage alone reads the first
    n.sync1 = events_in;
    n.sync2 = r.sync1;
    n.prev  = r.sync2;
    // edges, so a held level is one event and a 0-to-1 change is caught
    rise = r.sync2 & ~r.prev;

    adr   = avl_req_in.address;
    wmask = {{8{avl_req_in.byteenable[3]}}, {8{avl_req_in.byteenable[2]}},
             {8{avl_req_in.byteenable[1]}}, {8{avl_req_in.byteenable[0]}}};
    wdat  = avl_req_in.writedata[19:0];
    wm    = wmask[19:0];
    bus_req = avl_req_in.read | avl_req_in.write;
    // write lands at the edge where the master sees waitrequest low
    do_wr = avl_req_in.write & ~r.waitrequest;

    // sticky status
    // set wins over a clear in the same cycle
    n.status = r.status | rise;
    if (do_wr && adr == smer_pkg::OFS_STATUS) begin
      n.status = (r.status & ~(wdat & wm)) | rise;
    end

    // each enable register masked by its capability
    // enables only hold bits whose path exists
    if (do_wr) begin
      if (adr == smer_pkg::OFS_ACPI_EN) begin
        n.acpi_en = ((r.acpi_en & ~wm) | (wdat & wm)) & smer_pkg::CAP_ACPI;
      end else if (adr == smer_pkg::OFS_SMI_EN) begin
        n.smi_en = ((r.smi_en & ~wm) | (wdat & wm)) & smer_pkg::CAP_SMI;
      end else if (adr == smer_pkg::OFS_RELOAD_EN) begin
        n.reload_en = ((r.reload_en & ~wm) | (wdat & wm))
                      & smer_pkg::CAP_RELOAD;
      end else if (adr == smer_pkg::OFS_RES_C2C3) begin
        n.res_c2c3 = ((r.res_c2c3 & ~wm) | (wdat & wm))
                     & smer_pkg::CAP_C2C3;
      end else if (adr == smer_pkg::OFS_RES_POS) begin
        n.res_pos = ((r.res_pos & ~wm) | (wdat & wm)) & smer_pkg::CAP_POS;
      end else if (adr == smer_pkg::OFS_RES_SLEEP) begin
        n.res_sleep = ((r.res_sleep & ~wm) | (wdat & wm))
                      & smer_pkg::CAP_SLEEP;
      end else if (adr == smer_pkg::OFS_CTRL) begin
        if (avl_req_in.byteenable[0]) begin
          n.acpi_route_select = avl_req_in.writedata[0];
        end
      end
    end

    summary = {|(r.status & smer_pkg::GRP_PINS),
               |(r.status & smer_pkg::GRP_USB),
               |(r.status & smer_pkg::GRP_MISC),
               |(r.status & smer_pkg::GRP_TIMER),
               |(r.status & smer_pkg::GRP_TRAP),
               |(r.status & smer_pkg::GRP_ACT),
               |(r.status & smer_pkg::GRP_SMB)};

    // unmapped reads answer zero
    rd_val = 32'h00000000;
    if (adr == smer_pkg::OFS_STATUS) begin
      rd_val = {12'h000, r.status};
    end else if (adr == smer_pkg::OFS_ACPI_EN) begin
      rd_val = {12'h000, r.acpi_en};
    end else if (adr == smer_pkg::OFS_SMI_EN) begin
      rd_val = {12'h000, r.smi_en};
    end else if (adr == smer_pkg::OFS_RELOAD_EN) begin
      rd_val = {12'h000, r.reload_en};
    end else if (adr == smer_pkg::OFS_RES_C2C3) begin
      rd_val = {12'h000, r.res_c2c3};
    end else if (adr == smer_pkg::OFS_RES_POS) begin
      rd_val = {12'h000, r.res_pos};
    end else if (adr == smer_pkg::OFS_RES_SLEEP) begin
      rd_val = {12'h000, r.res_sleep};
    end else if (adr == smer_pkg::OFS_CTRL) begin
      rd_val = {31'h00000000, r.acpi_route_select};
    end else if (adr == smer_pkg::OFS_SUMMARY) begin
      rd_val = {25'h0000000, summary};
    end

    // one wait cycle per access, then waitrequest low for one cycle
    n.waitrequest = ~(bus_req & r.waitrequest);
    if (bus_req && r.waitrequest) begin
      n.readdata = rd_val;
    end

    acpi_req     = |(r.status & r.acpi_en);
    smi_only_req = |(r.status & r.smi_en);
    n.sci = acpi_req & r.acpi_route_select;
    n.smi = (acpi_req & ~r.acpi_route_select) | smi_only_req;

    // reload pulse on each enabled activity edge
    n.reload = |(rise & r.reload_en);

    // resume enable chosen by current power state
    // slave transfer resumes from c2/c3, pos and sleep states
    res_sel = 20'h00000;
    if (power_state_machine_in[smer_pkg::PS_C2]) begin
      res_sel = r.res_c2c3 & ~(20'h00001 << smer_pkg::EV_BUS_MASTER);
    end else if (power_state_machine_in[smer_pkg::PS_C3]) begin
      res_sel = r.res_c2c3;
    end else if (power_state_machine_in[smer_pkg::PS_POS]) begin
      res_sel = r.res_pos;
    end else if (power_state_machine_in[smer_pkg::PS_STD] ||
                 power_state_machine_in[smer_pkg::PS_STR] ||
                 power_state_machine_in[smer_pkg::PS_SOFF]) begin
      res_sel = r.res_sleep;
    end
    // resume stays high while a status bit enabled for the current state is set
    n.resume = |(r.status & res_sel);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  assign avl_rsp_out.readdata    = r.readdata;
  assign avl_rsp_out.waitrequest = r.waitrequest;
  assign sci_out                 = r.sci;
  assign smi_out                 = r.smi;
  assign inactivity_reload_out   = r.reload;
  assign resume_out              = r.resume;

endmodule

// ==== tb/smer_router_monitor.sv ====
// concurrent checks on the ports of the event router
`timescale 1ns/1ps
module smer_router_monitor (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_n_in,
  input  wire smer_pkg::smer_avl_req_t avl_req_in,
  input  wire smer_pkg::smer_avl_rsp_t avl_rsp_out,
  input  wire logic [19:0]             events_in,
  input  wire logic [6:0]              power_state_machine_in,
  input  wire logic                    sci_out,
  input  wire logic                    smi_out,
  input  wire logic                    inactivity_reload_out,
  input  wire logic                    resume_out
);
  logic seen_r;
  logic route_r;
  logic wr_acc;
  logic req_any;
  assign wr_acc  = avl_req_in.write && !avl_rsp_out.waitrequest;
  assign req_any = avl_req_in.read || avl_req_in.write;
  // shadow of the route select, updated on the accepted write edge only
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_r  <= 1'b0;
      route_r <= 1'b0;
    end else begin
      seen_r <= seen_r | (|events_in);
      if (wr_acc && avl_req_in.address == smer_pkg::OFS_CTRL &&
          avl_req_in.byteenable[0])
        route_r <= avl_req_in.writedata[0];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_wait_one: assert property (
    req_any && avl_rsp_out.waitrequest |=> !avl_rsp_out.waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_pulse: assert property (
    !avl_rsp_out.waitrequest |=> avl_rsp_out.waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (
    !req_any && avl_rsp_out.waitrequest |=> avl_rsp_out.waitrequest)
    else $error("answer without request");
  a_high_zero: assert property (
    !avl_rsp_out.waitrequest |-> avl_rsp_out.readdata[31:20] == 12'h000)
    else $error("upper read bits not zero");
  a_summary_width: assert property (
    !avl_rsp_out.waitrequest && $past(avl_req_in.read &&
    avl_req_in.address == smer_pkg::OFS_SUMMARY)
    |-> avl_rsp_out.readdata[31:7] == 25'h0)
    else $error("summary read wider than seven groups");
  a_quiet_boot: assert property (
    !seen_r |-> !sci_out && !smi_out && !resume_out &&
    !inactivity_reload_out)
    else $error("output active without any event");
  a_sci_route: assert property (
    !route_r && $past(!route_r) |-> !sci_out)
    else $error("sci raised while routed to smi");
  a_sci_hold: assert property (
    $fell(sci_out) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("sci dropped without a register write");
  a_smi_hold: assert property (
    $fell(smi_out) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("smi dropped without a register write");
  a_fon_quiet: assert property (
    $past(power_state_machine_in[smer_pkg::PS_FON]) &&
    $past(power_state_machine_in[smer_pkg::PS_FON], 2) |-> !resume_out)
    else $error("resume raised in full on");
endmodule
bind smer_router smer_router_monitor mon_u (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avl_req_in(avl_req_in),
  .avl_rsp_out(avl_rsp_out), .events_in(events_in),
  .power_state_machine_in(power_state_machine_in), .sci_out(sci_out),
  .smi_out(smi_out), .inactivity_reload_out(inactivity_reload_out),
  .resume_out(resume_out));

// ==== tb/smer_router_tb.sv ====
// self-checking bench for the event router registers and event paths
`timescale 1ns/1ps
module smer_router_tb;
  logic                    clk_sys_in;
  logic                    rst_n_in;
  smer_pkg::smer_avl_req_t req;
  smer_pkg::smer_avl_rsp_t rsp;
  logic [19:0]             events_in;
  logic [6:0]              psm;
  logic                    sci, smi, reload, resume;
  logic [31:0]             q;
  int                      error_cnt = 0;
  int                      n_tests = 0;
  int                      rl_cnt = 0;
  logic [19:0] caps [6] = '{smer_pkg::CAP_ACPI, smer_pkg::CAP_SMI,
    smer_pkg::CAP_RELOAD, smer_pkg::CAP_C2C3, smer_pkg::CAP_POS,
    smer_pkg::CAP_SLEEP};
  smer_router dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .avl_req_in(req), .avl_rsp_out(rsp), .events_in(events_in),
    .power_state_machine_in(psm), .sci_out(sci), .smi_out(smi),
    .inactivity_reload_out(reload), .resume_out(resume));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // the reload output is a single-cycle pulse, so it is counted
  always @(posedge clk_sys_in) if (reload === 1'b1) rl_cnt++;
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string nm);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= {!w, w, a, d, 4'hF};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 40);
    if (n >= 40) error_cnt++;
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e, "readdata");
  endtask
  task automatic ev(input int b);
    events_in[b] <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    events_in[b] <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic states(input logic [6:0] e);
    for (int s = 0; s < 7; s++) begin
      psm <= 7'(1 << s);
      repeat (3) @(posedge clk_sys_in);
      chk(resume, e[s], "resume");
    end
    psm <= 7'h01;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    events_in = '0;
    psm = 7'h01;
    rst_n_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
    ev(9);
    rd(smer_pkg::OFS_STATUS, 32'h200);
    rd(smer_pkg::OFS_SUMMARY, 32'h8);
    chk(sci | smi, 32'h0, "irq");
    acc(1'b1, smer_pkg::OFS_STATUS, 32'h200);
    rd(smer_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 8'(4 * i + 4), 32'hFFFFFFFF);
      rd(8'(4 * i + 4), {12'h0, caps[i]});
    end
    acc(1'b1, smer_pkg::OFS_CTRL, 32'hFFFFFFFF);
    rd(smer_pkg::OFS_CTRL, 32'h1);
    acc(1'b1, 8'h24, 32'hFFFFFFFF);
    rd(8'h24, 32'h0);
    ev(1);
    chk({sci, smi}, 32'h2, "route sci");
    rd(smer_pkg::OFS_SUMMARY, 32'h1);
    acc(1'b1, smer_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    chk({sci, smi}, 32'h1, "route smi");
    states(7'h7E);
    acc(1'b1, smer_pkg::OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk_sys_in);
    chk({sci, smi}, 32'h0, "cleared");
    ev(3);
    states(7'h0E);
    acc(1'b1, smer_pkg::OFS_STATUS, 32'hFFFFF);
    acc(1'b1, smer_pkg::OFS_CTRL, 32'h1);
    ev(10);
    chk({sci, smi}, 32'h1, "smi only");
    acc(1'b1, smer_pkg::OFS_STATUS, 32'hFFFFF);
    q = rl_cnt;
    ev(8);
    ev(9);
    ev(4);
    ev(11);
    chk(rl_cnt - q, 32'h2, "reload count");
    rd(smer_pkg::OFS_STATUS, 32'hB10);
    chk({sci, smi}, 32'h3, "lpt and timer");
    final_report();
  end
endmodule
